// >>> logic/key_matrix_scan_debounce.sv
// Key matrix scanner with two-sample debounce and LED key display
`include "kms_defs.svh"
`default_nettype none
module key_matrix_scan_debounce
  import kms_pkg::*;
#(
  parameter int ROWS        = `KMS_ROWS,
  parameter int COLS        = `KMS_COLS,
  parameter int TICK_CYCLES = `KMS_TICK_CYCLES
) (
  input  wire logic            I_CORE_CLK,
  input  wire logic            I_RST_N,
  input  wire logic [COLS-1:0] I_RETURN,
  output logic      [ROWS-1:0] O_SCAN,
  output logic [`KMS_LED_W-1:0] O_LED,
  output logic                 O_KEY_PRESS_EVENT,
  output logic                 O_SCAN_INTERVAL_TICK
);
  localparam int IDX_W = (ROWS > 1) ? $clog2(ROWS) : 1;
  localparam logic [ROWS-1:0] ALL_LINES = '1;

  // Key numbers must leave the all-ones code free for several keys
  if (ROWS < 1 || COLS < 1 || ROWS * COLS > 2 ** `KMS_LED_W - 2) begin : g_size
    $error("Matrix size does not fit the LED code");
  end
  if (TICK_CYCLES < 2) begin : g_tick
    $error("TICK_CYCLES too small");
  end

  function automatic int first_set(input logic [COLS-1:0] v);
    int r;
    r = 0;
    for (int i = COLS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = i;
      end
    end
    return r;
  endfunction : first_set

  state_e               state_q;
  logic [IDX_W-1:0]     idx_q;
  logic [ROWS-1:0]      scan_q;
  scan_res_s            acc_q;
  scan_res_s            prev_q;
  logic                 prev_ok_q;
  logic [`KMS_LED_W-1:0] led_q;
  logic                 event_q;
  logic [31:0]          tick_cnt_q;
  logic                 tick_q;
  logic                 agree;
  logic                 last_line;

  assign O_SCAN               = scan_q;
  assign O_LED                = led_q;
  assign O_KEY_PRESS_EVENT    = event_q;
  assign O_SCAN_INTERVAL_TICK = tick_q;
  assign agree     = prev_ok_q && (acc_q == prev_q);
  assign last_line = (idx_q == IDX_W'(ROWS - 1));

  // ---------------------------------------------------------------
  // Interval timer
  // ---------------------------------------------------------------
  // Free running from reset; events do not restart it, every gap is TICK_CYCLES
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      tick_q     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Key-press event
  // ---------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      event_q <= 1'b0;
    end else begin
      event_q <= (state_q == ST_WAIT) && (|I_RETURN) && !event_q;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer and scan lines
  // ---------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_q <= ST_WAIT;
      scan_q  <= ALL_LINES;
      idx_q   <= '0;
    end else begin
      unique case (state_q)
        ST_WAIT: begin
          scan_q <= ALL_LINES;
          if (event_q) begin
            state_q <= ST_SCAN;
            idx_q   <= '0;
            scan_q  <= ROWS'(1);
          end
        end
        ST_SCAN: begin
          if (last_line) begin
            state_q <= ST_JUDGE;
            scan_q  <= '0;
          end else begin
            idx_q  <= idx_q + IDX_W'(1);
            scan_q <= scan_q << 1;
          end
        end
        ST_JUDGE: begin
          if (agree && !acc_q.hit) begin
            state_q <= ST_WAIT;
            scan_q  <= ALL_LINES;
          end else begin
            state_q <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (tick_q) begin
            state_q <= ST_SCAN;
            idx_q   <= '0;
            scan_q  <= ROWS'(1);
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Scan result and previous detection
  // ---------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      acc_q     <= '0;
      prev_q    <= '0;
      prev_ok_q <= 1'b0;
    end else begin
      if ((state_q == ST_WAIT && event_q) ||
          (state_q == ST_HOLD && tick_q)) begin
        acc_q <= '0;
      end else if (state_q == ST_SCAN && |I_RETURN) begin
        acc_q.hit <= 1'b1;
        // Second hit anywhere, or two returns on one line, means several
        acc_q.multi <= acc_q.hit || !$onehot(I_RETURN);
        acc_q.key <= `KMS_LED_W'(int'(idx_q) * COLS
                     + first_set(I_RETURN) + 1);
      end
      if (state_q == ST_JUDGE) begin
        prev_q    <= acc_q;
        prev_ok_q <= !(agree && !acc_q.hit);
      end else if (state_q == ST_WAIT) begin
        prev_ok_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // LED display
  // ---------------------------------------------------------------
  // Led bit 0 is the first output line, bit 4 the last
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      led_q <= `KMS_LED_OFF;
    end else if (state_q == ST_JUDGE && agree) begin
      if (!acc_q.hit) begin
        led_q <= `KMS_LED_OFF;
      end else if (acc_q.multi) begin
        led_q <= `KMS_LED_ALL;
      end else begin
        led_q <= acc_q.key;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [31:0] gap_q;
  logic        seen_q;
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      gap_q  <= 32'h0000_0000;
      seen_q <= 1'b0;
    end else if (tick_q) begin
      gap_q  <= 32'h0000_0001;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);

  a_init_lines: assert property (
    !$past(I_RST_N) |-> (O_SCAN == ALL_LINES && O_LED == `KMS_LED_OFF))
    else $error("Scan lines not all active after reset");
  a_wait_lines: assert property (
    (state_q == ST_WAIT && !$past(state_q == ST_JUDGE)) |->
    O_SCAN == ALL_LINES)
    else $error("Scan lines not all active while waiting");
  a_event_raise: assert property (
    (state_q == ST_WAIT && |I_RETURN && !O_KEY_PRESS_EVENT) |=>
    O_KEY_PRESS_EVENT)
    else $error("Closed return did not raise key event");
  a_event_scan: assert property (
    O_KEY_PRESS_EVENT |=> (state_q == ST_SCAN && O_SCAN == ROWS'(1))
    ##1 $onehot(O_SCAN))
    else $error("Key event did not start a scan");
  a_scan_onehot: assert property (
    state_q == ST_SCAN |-> $onehot(O_SCAN))
    else $error("More than one scan line active in scan");
  a_tick_period: assert property (
    (tick_q && seen_q) |-> gap_q == 32'(TICK_CYCLES))
    else $error("Interval tick period wrong");
  a_led_agree: assert property (
    $changed(O_LED) |-> $past(state_q == ST_JUDGE && agree))
    else $error("LEDs changed without two agreeing detections");
  a_led_value: assert property (
    (state_q == ST_JUDGE && agree && acc_q.hit && !acc_q.multi) |=>
    O_LED == $past(acc_q.key))
    else $error("LEDs do not show accepted key number");
  a_led_multi: assert property (
    (state_q == ST_JUDGE && agree && acc_q.multi) |=>
    O_LED == `KMS_LED_ALL)
    else $error("Several keys did not light all LEDs");
  a_none_wait: assert property (
    (state_q == ST_JUDGE && agree && !acc_q.hit) |=>
    (O_LED == `KMS_LED_OFF && state_q == ST_WAIT && O_SCAN == ALL_LINES))
    else $error("No key did not return to waiting");

  c_key_shown: cover property (
    state_q == ST_JUDGE && agree && acc_q.hit && !acc_q.multi);
  c_multi: cover property (state_q == ST_JUDGE && agree && acc_q.multi);
  c_bounce: cover property (state_q == ST_JUDGE && prev_ok_q && !agree);
  c_release: cover property (state_q == ST_JUDGE && agree && !acc_q.hit);
endmodule : key_matrix_scan_debounce
`default_nettype wire

// >>> logic/kms_defs.svh
// Constants for the key matrix scanner with debounce
`ifndef KMS_DEFS_SVH
`define KMS_DEFS_SVH
`define KMS_ROWS          4
`define KMS_COLS          4
`define KMS_LED_W         5
`define KMS_CLK_MHZ       125
`define KMS_TICK_MS       30
`define KMS_TICK_CYCLES   (`KMS_TICK_MS * 1000 * `KMS_CLK_MHZ)
`define KMS_LED_OFF       5'h00
`define KMS_LED_ALL       5'h1F
`endif

// >>> logic/kms_pkg.sv
// Types for the key matrix scanner with debounce
`default_nettype none
package kms_pkg;
  typedef enum logic [1:0] {
    ST_WAIT,
    ST_SCAN,
    ST_JUDGE,
    ST_HOLD
  } state_e;

  typedef struct packed {
    logic       hit;
    logic       multi;
    logic [4:0] key;
  } scan_res_s;
endpackage : kms_pkg
`default_nettype wire

// >>> tb/key_matrix_model.sv
// Behavioural 4x4 switch matrix with one diode per key
`default_nettype none
module key_matrix_model (
  input  wire logic [15:0] i_pressed,
  input  wire logic [3:0]  i_scan,
  output logic      [3:0]  o_return
);
  timeunit 1ns;
  timeprecision 1ns;
  // Diodes keep two closed keys from shorting scan lines
  always_comb begin
    o_return = 4'h0;
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < 4; c++) begin
        if (i_scan[r] && i_pressed[r*4+c]) o_return[c] = 1'b1;
      end
    end
  end
endmodule : key_matrix_model
`default_nettype wire

// >>> tb/key_matrix_scan_debounce_test.sv
// Self-checking bench for the key matrix scanner
`default_nettype none
module key_matrix_scan_debounce_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 64;
  logic        clk;
  logic        rst_n;
  logic [15:0] pressed;
  logic [3:0]  ret;
  logic [3:0]  scan;
  logic [4:0]  led;
  logic        ev;
  logic        tick;
  logic [31:0] rng;
  int          n_errors = 0;
  int          tests_run = 0;

  key_matrix_scan_debounce #(.TICK_CYCLES(TICK)) i_dut (
    .I_CORE_CLK          (clk),
    .I_RST_N             (rst_n),
    .I_RETURN            (ret),
    .O_SCAN              (scan),
    .O_LED               (led),
    .O_KEY_PRESS_EVENT   (ev),
    .O_SCAN_INTERVAL_TICK(tick)
  );
  key_matrix_model i_keys (
    .i_pressed(pressed),
    .i_scan   (scan),
    .o_return (ret)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // -----------------------------------------------
  // Reference model and helpers
  // -----------------------------------------------
  function automatic logic [4:0] exp_led(input logic [15:0] p);
    int cnt;
    int k;
    cnt = 0;
    k = 0;
    for (int i = 0; i < 16; i++) begin
      if (p[i]) begin
        cnt++;
        k = i + 1;
      end
    end
    return (cnt > 1) ? 5'h1F : k[4:0];
  endfunction : exp_led

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  // Long enough for every scenario with margin; a hang is a mismatch
  initial begin
    #(8 * TICK * 300);
    n_errors++;
    wrap_up();
  end

  initial begin
    int          gap;
    logic [15:0] p;
    rst_n   = 1'b0;
    pressed = 16'h0000;
    rng     = 32'h0000_808e;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    step();
    check("scan idle", scan, 4'hF);
    for (gap = 0; gap < 2 * TICK && tick !== 1'b1; gap++) step();
    step();
    gap = 1;
    while (tick !== 1'b1 && gap < 2 * TICK) begin
      step();
      gap++;
    end
    check("tick period", gap, TICK);
    for (int n = 0; n < 11; n++) begin
      rng = xs(rng);
      p = (n == 0) ? 16'h8000 : (n == 1) ? 16'h0001 : 16'h0001 << rng[3:0];
      // Byte rotation always adds a second, distinct key
      if (n == 2) p = p | {p[7:0], p[15:8]};
      check("scan wait", scan, 4'hF);
      @(posedge clk);
      pressed <= p;
      for (int i = 0; i < 20 && ev !== 1'b1; i++) step();
      check("event", ev, 1'b1);
      for (int i = 0; i < 4; i++) begin
        step();
        if (i == 0) check("event pulse", ev, 1'b0);
        check("scan line", scan, 32'h1 << i);
      end
      check("led early", led, 5'h00);
      if (n == 3) begin
        p = {p[7:0], p[15:8]};
        @(posedge clk);
        pressed <= p;
      end
      for (int i = 0; i < 4 * TICK && led !== exp_led(p); i++) step();
      check("led key", led, exp_led(p));
      @(posedge clk);
      pressed <= 16'h0000;
      for (int i = 0; i < 4 * TICK && scan !== 4'hF; i++) step();
      check("led off", led, 5'h00);
      check("scan back", scan, 4'hF);
    end
    wrap_up();
  end
endmodule : key_matrix_scan_debounce_test
`default_nettype wire
